// [rx_datalink_route_cas_change.sv]
// receive data-link routing and signalling change flags with an apb register slave
//
// Contract
// - select 00 sends link bits to lapd controller 1 and the serial output.
// - select 01 sends link bits to the serial output only.
// - select 10 sends link bits to the overhead and serial outputs.
// - select 11 replaces every link bit with a one.
// - only lapd controller 1 is connected to the link bits.
// - first change register: channels 0..7, msb is channel 0.
// - second change register: channels 8..15, msb is channel 8.
// - flags are set only while the stream uses channel-associated signalling; otherwise they are held at zero.
// - route select and all change flags reset to zero.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module rx_datalink_route_cas_change
    import rx_dlcas_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // incoming bit stream from the framer
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    input wire logic rx_bit_is_link,
    // extracted signalling from the framer
    input wire logic cas_active,
    input wire logic sig_valid,
    input wire logic [4:0] sig_channel,
    input wire logic [SIG_W-1:0] sig_bits,
    // serial output
    output logic rx_serial_out,
    output logic rx_serial_valid,
    // overhead output
    output logic rx_overhead_out,
    output logic rx_overhead_valid,
    // receive lapd controller 1
    output logic lapd1_bit,
    output logic lapd1_valid,
    // interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] reg_addr);
        reg_hit = (a == reg_addr);
    endfunction : reg_hit

    logic hit_link_sel;
    logic hit_cas_lo;
    logic hit_cas_hi;
    logic hit_irq_status;
    logic hit_irq_mask;
    logic hit_any;

    always_comb begin
        hit_link_sel = reg_hit(paddr, ADDR_LINK_SEL);
        hit_cas_lo = reg_hit(paddr, ADDR_CAS_0_7);
        hit_cas_hi = reg_hit(paddr, ADDR_CAS_8_15);
        hit_irq_status = reg_hit(paddr, ADDR_IRQ_STATUS);
        hit_irq_mask = reg_hit(paddr, ADDR_IRQ_MASK);
        hit_any = hit_link_sel | hit_cas_lo | hit_cas_hi | hit_irq_status | hit_irq_mask;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb response: one wait state, read data captured on the first access edge

    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [31:0] rd_value;
    logic complete;
    logic wr_commit;
    logic rd_commit;

    route_e link_sel;
    logic [7:0] cas_flags [GROUPS];
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;

    always_comb begin
        rd_value = 32'h0000_0000;
        if (hit_link_sel) begin
            rd_value[LINK_SEL_LSB +: 2] = link_sel;
        end else if (hit_cas_lo) begin
            rd_value[7:0] = cas_flags[0];
        end else if (hit_cas_hi) begin
            rd_value[7:0] = cas_flags[1];
        end else if (hit_irq_status) begin
            rd_value[IRQ_W-1:0] = irq_status;
        end else if (hit_irq_mask) begin
            rd_value[IRQ_W-1:0] = irq_mask;
        end
    end

    always_comb begin
        next_prdata = prdata;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        if (psel && penable && !pready) begin
            next_pready = 1'b1;
            next_prdata = pwrite ? 32'h0000_0000 : rd_value;
            next_pslverr = !hit_any;
        end
    end

    always_comb begin
        complete = psel && penable && pready;
        wr_commit = complete && pwrite && !pslverr && pstrb[0];
        rd_commit = complete && !pwrite && !pslverr;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= RST_PRDATA;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control registers

    route_e next_link_sel;
    logic [IRQ_W-1:0] next_irq_mask;

    always_comb begin
        next_link_sel = link_sel;
        next_irq_mask = irq_mask;
        if (wr_commit && hit_link_sel) begin
            next_link_sel = route_e'(pwdata[LINK_SEL_LSB +: 2]);
        end
        if (wr_commit && hit_irq_mask) begin
            next_irq_mask = pwdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_sel <= route_e'(RST_LINK_SEL);
            irq_mask <= RST_IRQ_MASK;
        end else begin
            link_sel <= next_link_sel;
            irq_mask <= next_irq_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // signalling change tracking, one group per change register

    logic [GROUPS-1:0] grp_event;

    generate
        for (genvar g = 0; g < GROUPS; g++) begin : gen_group
            logic grp_upd;
            logic [7:0] grp_clr;
            logic grp_hit;

            assign grp_hit = (g == 0) ? hit_cas_lo : hit_cas_hi;
            // channels 16 and up belong to other logic and are ignored here
            assign grp_upd = sig_valid && (sig_channel[4:3] == 2'(g));
            // clear only what the completing read returned
            assign grp_clr = (rd_commit && grp_hit) ? prdata[7:0] : 8'h00;

            cas_change_group u_group (
                .pclk(pclk),
                .presetn(presetn),
                .cas_active(cas_active),
                .upd_valid(grp_upd),
                .upd_chan(sig_channel[2:0]),
                .upd_bits(sig_bits),
                .clr_mask(grp_clr),
                .flags(cas_flags[g]),
                .set_event(grp_event[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status, mask and output

    logic [IRQ_W-1:0] next_irq_status;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_W-1:0] irq_set;
    logic next_irq;

    always_comb begin
        irq_set = '0;
        irq_set[IRQ_BIT_CAS_0_7] = grp_event[0];
        irq_set[IRQ_BIT_CAS_8_15] = grp_event[1];
        irq_clr = (rd_commit && hit_irq_status) ? prdata[IRQ_W-1:0] : '0;
        // a new event wins over the clearing read
        next_irq_status = (irq_status & ~irq_clr) | irq_set;
        next_irq = |(irq_status & irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= RST_IRQ_STATUS;
            irq <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // data-link steering

    logic next_serial_out;
    logic next_serial_valid;
    logic next_overhead_out;
    logic next_overhead_valid;
    logic next_lapd1_bit;
    logic next_lapd1_valid;

    always_comb begin
        next_serial_out = rx_serial_out;
        next_serial_valid = 1'b0;
        next_overhead_out = rx_overhead_out;
        next_overhead_valid = 1'b0;
        next_lapd1_bit = lapd1_bit;
        next_lapd1_valid = 1'b0;
        if (rx_bit_valid) begin
            next_serial_valid = 1'b1;
            next_serial_out = rx_bit;
            if (rx_bit_is_link) begin
                unique case (link_sel)
                    ROUTE_LAPD_SER: begin
                        // lapd controller 1 is the only lapd tap on the link
                        next_lapd1_bit = rx_bit;
                        next_lapd1_valid = 1'b1;
                    end
                    ROUTE_SER: begin
                        next_serial_out = rx_bit;
                    end
                    ROUTE_OH_SER: begin
                        next_overhead_out = rx_bit;
                        next_overhead_valid = 1'b1;
                    end
                    ROUTE_FORCE_ONE: begin
                        next_serial_out = 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_serial_out <= 1'b1;
            rx_serial_valid <= 1'b0;
            rx_overhead_out <= 1'b1;
            rx_overhead_valid <= 1'b0;
            lapd1_bit <= 1'b1;
            lapd1_valid <= 1'b0;
        end else begin
            rx_serial_out <= next_serial_out;
            rx_serial_valid <= next_serial_valid;
            rx_overhead_out <= next_overhead_out;
            rx_overhead_valid <= next_overhead_valid;
            lapd1_bit <= next_lapd1_bit;
            lapd1_valid <= next_lapd1_valid;
        end
    end

endmodule : rx_datalink_route_cas_change

// [rx_dlcas_pkg.sv]
// constants and types shared by the data-link route and signalling change block
package rx_dlcas_pkg;

    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_LINK_SEL = 12'h10c;
    localparam logic [11:0] IDX_CAS_0_7 = 12'h10d;
    localparam logic [11:0] IDX_CAS_8_15 = 12'h10e;
    localparam logic [11:0] IDX_IRQ_STATUS = 12'h120;
    localparam logic [11:0] IDX_IRQ_MASK = 12'h121;

    localparam logic [11:0] ADDR_LINK_SEL = {IDX_LINK_SEL[9:0], 2'b00};
    localparam logic [11:0] ADDR_CAS_0_7 = {IDX_CAS_0_7[9:0], 2'b00};
    localparam logic [11:0] ADDR_CAS_8_15 = {IDX_CAS_8_15[9:0], 2'b00};
    localparam logic [11:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS[9:0], 2'b00};
    localparam logic [11:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK[9:0], 2'b00};

    // data-link destination select
    typedef enum logic [1:0] {
        ROUTE_LAPD_SER = 2'b00,
        ROUTE_SER = 2'b01,
        ROUTE_OH_SER = 2'b10,
        ROUTE_FORCE_ONE = 2'b11
    } route_e;

    // field layout
    localparam int unsigned LINK_SEL_LSB = 0;
    localparam int unsigned SIG_W = 4;
    localparam int unsigned CH_PER_GROUP = 8;
    localparam int unsigned GROUPS = 2;
    localparam int unsigned IRQ_W = 2;
    localparam int unsigned IRQ_BIT_CAS_0_7 = 0;
    localparam int unsigned IRQ_BIT_CAS_8_15 = 1;

    // values after reset
    localparam logic [1:0] RST_LINK_SEL = 2'h0;
    localparam logic [7:0] RST_CAS_FLAGS = 8'h00;
    localparam logic [SIG_W-1:0] RST_SIG_LAST = 4'h0;
    localparam logic [1:0] RST_IRQ_STATUS = 2'h0;
    localparam logic [1:0] RST_IRQ_MASK = 2'h0;
    localparam logic [31:0] RST_PRDATA = 32'h0000_0000;

endpackage : rx_dlcas_pkg

// [cas_change_group.sv]
// change flags for one group of eight signalling channels
`timescale 1ns/1ps
module cas_change_group
    import rx_dlcas_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // signalling updates
    input wire logic cas_active,
    input wire logic upd_valid,
    input wire logic [2:0] upd_chan,
    input wire logic [SIG_W-1:0] upd_bits,
    // read side
    input wire logic [7:0] clr_mask,
    output logic [7:0] flags,
    output logic set_event
);

    logic [SIG_W-1:0] last [CH_PER_GROUP];
    logic [SIG_W-1:0] next_last [CH_PER_GROUP];
    logic [7:0] next_flags;
    logic [7:0] set_vec;

    always_comb begin
        next_last = last;
        set_vec = 8'h00;
        if (cas_active && upd_valid) begin
            if (upd_bits != last[upd_chan]) begin
                // msb is the lowest channel of the group
                set_vec[3'(3'd7 - upd_chan)] = 1'b1;
            end
            next_last[upd_chan] = upd_bits;
        end
        // while cas is active only bits actually returned by a read are cleared; a new set wins
        next_flags = (flags & ~clr_mask) | set_vec;
        if (!cas_active) begin
            next_flags = RST_CAS_FLAGS;
        end
    end

    assign set_event = |set_vec;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= RST_CAS_FLAGS;
            for (int i = 0; i < CH_PER_GROUP; i++) begin
                last[i] <= RST_SIG_LAST;
            end
        end else begin
            flags <= next_flags;
            last <= next_last;
        end
    end

endmodule : cas_change_group

// [rx_dlcas_chk.sv]
// port assertions for the route and signalling block
`timescale 1ns/1ps
module rx_dlcas_chk (
    // clock, reset, bus answer
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // stream in and out
    input wire logic rx_bit_valid,
    input wire logic rx_bit,
    input wire logic rx_bit_is_link,
    input wire logic rx_serial_out,
    input wire logic rx_serial_valid,
    input wire logic rx_overhead_out,
    input wire logic rx_overhead_valid,
    input wire logic lapd1_bit,
    input wire logic lapd1_valid
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_serial_each: assert property (rx_bit_valid |=> rx_serial_valid)
        else $error("serial pulse lost");
    a_serial_cause: assert property (rx_serial_valid |-> $past(rx_bit_valid))
        else $error("serial pulse without bit");
    a_plain_bits: assert property (rx_bit_valid && !rx_bit_is_link |=>
        rx_serial_out == $past(rx_bit) && !lapd1_valid && !rx_overhead_valid)
        else $error("payload bit misrouted");
    a_lapd_link: assert property (lapd1_valid |->
        $past(rx_bit_valid && rx_bit_is_link) && lapd1_bit == $past(rx_bit))
        else $error("lapd bit wrong");
    a_lapd_serial: assert property (lapd1_valid |->
        rx_serial_valid && rx_serial_out == lapd1_bit)
        else $error("lapd bit not on serial");
    a_oh_link: assert property (rx_overhead_valid |->
        $past(rx_bit_valid && rx_bit_is_link) && rx_overhead_out == $past(rx_bit))
        else $error("overhead bit wrong");
    a_dest_excl: assert property (!(lapd1_valid && rx_overhead_valid))
        else $error("two link destinations");
    a_wait_state: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after one wait");
    cover property (lapd1_valid);
    cover property (rx_overhead_valid);
    cover property (pready && pslverr);
endmodule : rx_dlcas_chk

bind rx_datalink_route_cas_change rx_dlcas_chk chk_u (.pclk, .presetn, .psel, .penable,
    .pready, .pslverr, .rx_bit_valid, .rx_bit, .rx_bit_is_link, .rx_serial_out,
    .rx_serial_valid, .rx_overhead_out, .rx_overhead_valid, .lapd1_bit, .lapd1_valid);

// [rx_framer_model.sv]
// behavioural receive framer: stream bits and signalling updates
`timescale 1ns/1ps
module rx_framer_model
    import rx_dlcas_pkg::*;
(
    // clock
    input wire logic pclk,
    // stream
    output logic rx_bit_valid = 1'b0,
    output logic rx_bit = 1'b1,
    output logic rx_bit_is_link = 1'b0,
    // signalling
    output logic cas_active = 1'b0,
    output logic sig_valid = 1'b0,
    output logic [4:0] sig_channel = 5'h00,
    output logic [SIG_W-1:0] sig_bits = 4'h0
);
    // released data lines (rx_bit, sig_bits) show the inverse of the last value; rx_bit_is_link and sig_channel hold
    task automatic send_bit(input logic l, input logic b);
        @(posedge pclk);
        rx_bit_valid <= 1'b1;
        rx_bit_is_link <= l;
        rx_bit <= b;
        @(posedge pclk);
        rx_bit_valid <= 1'b0;
        rx_bit <= ~b;
    endtask : send_bit
    task automatic send_sig(input logic [4:0] c, input logic [SIG_W-1:0] v);
        @(posedge pclk);
        sig_valid <= 1'b1;
        sig_channel <= c;
        sig_bits <= v;
        @(posedge pclk);
        sig_valid <= 1'b0;
        sig_bits <= ~v;
    endtask : send_sig
    task automatic set_cas(input logic on);
        @(posedge pclk);
        cas_active <= on;
    endtask : set_cas
endmodule : rx_framer_model

// [tb.sv]
// self-checking bench for the route and signalling block
`timescale 1ns/1ps
module tb;
    import rx_dlcas_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, er, rx_bit_valid, rx_bit, rx_bit_is_link;
    logic cas_active, sig_valid, rx_serial_out, rx_serial_valid;
    logic rx_overhead_out, rx_overhead_valid, lapd1_bit, lapd1_valid, irq;
    logic [4:0] sig_channel;
    logic [SIG_W-1:0] sig_bits;
    logic [31:0] seed = 32'ha8e693ec;
    int fail_count = 0, checks_done = 0, sel, cas;
    int last [16] = '{default: 0};
    int flg [2] = '{0, 0};

    always #12.5 pclk = ~pclk;

    rx_datalink_route_cas_change dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .rx_bit_valid, .rx_bit,
        .rx_bit_is_link, .cas_active, .sig_valid, .sig_channel, .sig_bits,
        .rx_serial_out, .rx_serial_valid, .rx_overhead_out, .rx_overhead_valid,
        .lapd1_bit, .lapd1_valid, .irq);
    rx_framer_model fr_u (.pclk, .rx_bit_valid, .rx_bit, .rx_bit_is_link,
        .cas_active, .sig_valid, .sig_channel, .sig_bits);

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // request held until pready is sampled high at a rising edge; only the watchdog ends a wait
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rc(input logic [11:0] a, input int e, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask : rc

    task automatic bit_chk(input logic l, input logic b);
        fr_u.send_bit(l, b);
        #1;
        chk("ser_v", 1, rx_serial_valid);
        chk("ser", (l && sel == 3) ? 1'b1 : b, rx_serial_out);
        chk("lapd_v", l && sel == 0, lapd1_valid);
        chk("oh_v", l && sel == 2, rx_overhead_valid);
        if (l && sel == 0) chk("lapd", b, lapd1_bit);
        if (l && sel == 2) chk("oh", b, rx_overhead_out);
    endtask : bit_chk

    task automatic sig_upd(input int c, input int v);
        fr_u.send_sig(c[4:0], v[3:0]);
        if (cas != 0 && v[3:0] != last[c]) flg[c / 8] |= 1 << (7 - c % 8);
        if (cas != 0) last[c] = v[3:0];
    endtask : sig_upd

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(25 * 20000);
        fail_count++;
        conclude();
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rc(ADDR_LINK_SEL, 0, "sel_rst");
        rc(ADDR_CAS_0_7, 0, "cas0_rst");
        rc(ADDR_CAS_8_15, 0, "cas1_rst");
        $display("reset test done");
        for (sel = 0; sel < 4; sel++) begin
            apb(1'b1, ADDR_LINK_SEL, sel);
            rc(ADDR_LINK_SEL, sel, "sel");
            for (int i = 0; i < 6; i++) bit_chk(i < 5, (i == 1) ? 1'b0 : 1'(rnd()));
        end
        $display("route test done");
        fr_u.set_cas(1'b1);
        cas = 1;
        for (int r = 0; r < 2; r++) begin
            for (int c = 0; c < 16; c++) sig_upd(c, (r == 1 && c % 2 == 1) ? last[c] : rnd());
            rc(ADDR_CAS_0_7, flg[0], "cas0");
            rc(ADDR_CAS_8_15, flg[1], "cas1");
            flg = '{0, 0};
        end
        fr_u.set_cas(1'b0);
        cas = 0;
        sig_upd(3, last[3] ^ 1);
        rc(ADDR_CAS_0_7, 0, "cas_off");
        fr_u.set_cas(1'b1);
        cas = 1;
        sig_upd(3, last[3]);
        rc(ADDR_CAS_0_7, 0, "cas_on");
        // a change lands on the very edge at which the read completes
        sig_upd(2, last[2] ^ 1);
        fork
            rc(ADDR_CAS_0_7, flg[0], "cas_race");
            begin
                repeat (2) @(posedge pclk);
                sig_upd(2, last[2] ^ 3);
            end
        join
        rc(ADDR_CAS_0_7, flg[0], "cas_keep");
        flg = '{0, 0};
        $display("signalling test done");
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0000_0000);
        apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0002);
        sig_upd(9, last[9] ^ 5);
        repeat (2) @(posedge pclk);
        #1;
        chk("irq", 1, irq);
        rc(ADDR_IRQ_STATUS, 2, "status");
        rc(ADDR_CAS_8_15, flg[1], "cas1_irq");
        flg = '{0, 0};
        chk("irq_clr", 0, irq);
        apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0000);
        sig_upd(9, last[9] ^ 2);
        repeat (3) @(posedge pclk);
        chk("irq_mask", 0, irq);
        apb(1'b1, ADDR_CAS_0_7, 32'h0000_00ff);
        rc(ADDR_CAS_0_7, 0, "cas0_ro");
        apb(1'b0, 12'h400, 32'h0000_0000);
        chk("unmapped", 1, er);
        chk("unmapped_d", 0, rd);
        $display("irq and bus test done");
        conclude();
    end
endmodule : tb
